// ==== hdl/uart_receiver_fifo_wakeup.sv ====
// Receive channel: start validation, assembly, error detection, eight-deep queue, watchdog, wake-up mode
`timescale 1ns/10ps
`include "uart_rx_consts.svh"

module uart_receiver_fifo_wakeup
(
  input  wire logic                  clock_i,           // 40 MHz crystal clock
  input  wire logic                  sys_rst_i,         // Async reset, active high
  input  wire uart_rx_pkg::reg_req_t reg_req_i,         // Register request
  output logic [7:0]                 reg_rdata_o,       // Read data, cycle after read
  input  wire logic                  rxd_i,             // Serial input pin
  input  wire logic                  rx_bit_clock_i,    // 16x or 1x receive clock pin
  input  wire logic                  tx_idle_flag_i,    // Transmitter empty
  input  wire logic                  tx_char_start_i,   // Transmitter begins a character
  output logic                       tx_ad_bit_o,       // Address/data bit for parity slot
  output logic [2:0]                 rx_fill_level_o,   // Queue level for bidding
  output logic                       rx_char_available_o, // Queue not empty
  output logic                       rx_queue_full_flag_o, // Queue full
  output logic                       watchdog_o,        // Watchdog expired and enabled
  output logic                       break_change_o     // Change-of-break status
);
  import uart_rx_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic rxd_s1_q, rxd_s2_q, bclk_s1_q, bclk_s2_q, bclk_s3_q;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rxd_s1_q  <= 1'b1;
      rxd_s2_q  <= 1'b1;
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
    end
    else
    begin
      rxd_s1_q  <= rxd_i;
      rxd_s2_q  <= rxd_s1_q;
      bclk_s1_q <= rx_bit_clock_i;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
    end
  end

  wire tick = bclk_s2_q & ~bclk_s3_q;
  wire fall = ~bclk_s2_q & bclk_s3_q;

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [7:0] mode0_q, mode1_q;
  logic       rx_en_q;
  wire        wr_mode0  = reg_req_i.wr && (reg_req_i.addr == `REG_MODE_ZERO);
  wire        wr_mode1  = reg_req_i.wr && (reg_req_i.addr == `REG_MODE_ONE);
  wire        wr_cmd    = reg_req_i.wr && (reg_req_i.addr == `REG_COMMAND);
  wire        cmd_en    = wr_cmd && reg_req_i.wdata[`CMD_RX_ENABLE_BIT];
  wire        cmd_dis   = wr_cmd && reg_req_i.wdata[`CMD_RX_DISABLE_BIT];
  wire        cmd_rsterr = wr_cmd && reg_req_i.wdata[`CMD_RESET_ERR_BIT];
  wire        cmd_clrbrk = wr_cmd && reg_req_i.wdata[`CMD_CLR_BRK_BIT];
  wire        cmd_clrwd = wr_cmd && reg_req_i.wdata[`CMD_CLR_WDOG_BIT];
  wire        rd_queue  = reg_req_i.rd && (reg_req_i.addr == `REG_RX_QUEUE);
  wire        x1_mode   = mode0_q[`M0_X1_MODE_BIT];
  wire        wdog_en   = mode0_q[`M0_WDOG_EN_BIT];
  wire [1:0]  par_mode  = mode1_q[4:3];
  wire        wakeup    = (par_mode == `M1_PAR_MODE_WAKEUP);
  wire        par_en    = (par_mode != 2'h2);
  wire        block_mode = mode1_q[`M1_ERR_BLOCK_BIT];
  wire [3:0]  nbits     = `MIN_DATA_BITS + {2'h0, mode1_q[1:0]};
  wire [3:0]  stop_idx  = nbits + {3'h0, par_en};
  wire        rx_active = rx_en_q | wakeup;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mode0_q <= `MODE_ZERO_RST;
      mode1_q <= `MODE_ONE_RST;
      rx_en_q <= 1'b0;
    end
    else
    begin
      if (wr_mode0)
        mode0_q <= reg_req_i.wdata;
      if (wr_mode1)
        mode1_q <= reg_req_i.wdata;
      if (cmd_en)
        rx_en_q <= 1'b1;
      else if (cmd_dis)
        rx_en_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------
  rx_state_t  state_q;
  logic [3:0] div_q, bit_q;
  logic [7:0] data_q;
  logic       pbit_q, prev_q, brk_act_q;
  logic [1:0] hi_cnt_q;
  logic       hold_q, phase_q, overrun_q;
  rxq_entry_t hold_ent_q;
  logic       brk_set, q_full, do_load;

  wire sample = x1_mode ? tick : (tick && (div_q == `SAMPLE_COUNT));
  wire edge_seen = tick && prev_q && !rxd_s2_q;
  wire at_stop = (bit_q == stop_idx);

  // Character completion terms
  wire        frm_err = !rxd_s2_q;
  wire        is_brk  = (data_q == 8'h00) && !(par_en && pbit_q) && !rxd_s2_q;
  wire        par_calc = ^data_q ^ pbit_q;
  wire        par_err = (par_mode == `M1_PAR_MODE_FORCE) ? (pbit_q != mode1_q[`M1_AD_BIT]) :
                        (par_mode == `M1_PAR_MODE_WITH)  ? (par_calc != mode1_q[`M1_AD_BIT]) : 1'b0;
  wire        par_slot = wakeup ? pbit_q : par_err;
  wire        accept  = rx_en_q || (wakeup && pbit_q);
  wire        done    = (state_q == ST_DATA) && sample && at_stop;
  rxq_entry_t new_ent;
  assign new_ent.data = is_brk ? 8'h00 : data_q;
  assign new_ent.err  = '{brk: is_brk, frm: frm_err, par: is_brk ? 1'b0 : par_slot};

  wire  start_ok = (state_q == ST_START) && sample && !rxd_s2_q;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q   <= ST_IDLE;
      div_q     <= 4'h0;
      bit_q     <= 4'h0;
      data_q    <= 8'h00;
      pbit_q    <= 1'b0;
      prev_q    <= 1'b1;
      hi_cnt_q  <= 2'h0;
      brk_act_q <= 1'b0;
    end
    else
    begin
      if (tick)
        prev_q <= rxd_s2_q;
      if (cmd_en)
        prev_q <= 1'b1;
      if (tick && state_q != ST_IDLE)
        div_q <= div_q + 4'h1;
      unique case (state_q)
        ST_IDLE:
        begin
          bit_q  <= 4'h0;
          data_q <= 8'h00;
          pbit_q <= 1'b0;
          if (rx_active && x1_mode && tick && !rxd_s2_q)
            state_q <= ST_DATA;
          else if (rx_active && !x1_mode && edge_seen)
          begin
            div_q   <= 4'h0;
            state_q <= ST_START;
          end
        end
        ST_START:
          if (sample)
            state_q <= rxd_s2_q ? ST_IDLE : ST_DATA;
        ST_DATA:
          if (sample)
          begin
            bit_q <= bit_q + 4'h1;
            if (bit_q < nbits)
              data_q[bit_q[2:0]] <= rxd_s2_q;
            else if (!at_stop)
              pbit_q <= rxd_s2_q;
            else if (is_brk)
              state_q <= ST_BREAK;
            else if (frm_err && data_q != 8'h00 && !x1_mode)
              state_q <= ST_FEHOLD;
            else
              state_q <= ST_IDLE;
          end
        ST_FEHOLD:
          if (tick && rxd_s2_q)
            state_q <= ST_IDLE;
          else if (tick && div_q == `DIV_LAST)
          begin
            div_q   <= 4'h0;
            state_q <= ST_START;
          end
        ST_BREAK:
        begin
          brk_act_q <= 1'b1;
          if (!rxd_s2_q)
            hi_cnt_q <= 2'h0;
          else if (hi_cnt_q == `BRK_END_EDGES - 2'h1)
          begin
            hi_cnt_q  <= 2'h0;
            brk_act_q <= 1'b0;
            prev_q    <= 1'b1;
            state_q   <= ST_IDLE;
          end
          else
            hi_cnt_q <= hi_cnt_q + 2'h1;
        end
      endcase
    end
  end

  assign brk_set = (done && is_brk) || (state_q == ST_BREAK && rxd_s2_q
                   && hi_cnt_q == `BRK_END_EDGES - 2'h1);

  // ----------------------------------------------------------------
  // Holding stage and overrun
  // ----------------------------------------------------------------
  assign do_load = hold_q && phase_q && tick && !q_full;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hold_q     <= 1'b0;
      phase_q    <= 1'b0;
      overrun_q  <= 1'b0;
      hold_ent_q <= '0;
    end
    else
    begin
      if (done && accept)
      begin
        hold_q     <= 1'b1;
        phase_q    <= 1'b0;
        hold_ent_q <= new_ent;
      end
      else if (do_load)
        hold_q <= 1'b0;
      else if (hold_q && fall)
        phase_q <= 1'b1;
      if (start_ok && hold_q && q_full)
        overrun_q <= 1'b1;
      else if (cmd_rsterr)
        overrun_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------
  rxq_entry_t q_mem_q [0:7];
  logic [2:0] wr_ptr_q, rd_ptr_q;
  logic [3:0] count_q;
  rx_err_t    block_q;
  wire        q_empty = (count_q == 4'h0);
  wire        do_pop  = rd_queue && !q_empty;
  rxq_entry_t head;
  assign q_full = (count_q == `RXQ_DEPTH);
  assign head   = q_mem_q[rd_ptr_q];

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_q <= 3'h0;
      rd_ptr_q <= 3'h0;
      count_q  <= 4'h0;
      block_q  <= '0;
      for (int i = 0; i < 8; i++)
        q_mem_q[i] <= '0;
    end
    else
    begin
      if (do_load)
      begin
        q_mem_q[wr_ptr_q] <= hold_ent_q;
        wr_ptr_q <= wr_ptr_q + 3'h1;
      end
      if (do_pop)
        rd_ptr_q <= rd_ptr_q + 3'h1;
      count_q <= count_q + {3'h0, do_load} - {3'h0, do_pop};
      if (!q_empty)
        block_q <= (cmd_rsterr ? '0 : block_q) | head.err;
      else if (cmd_rsterr)
        block_q <= '0;
    end
  end

  wire [2:0] err_view = q_empty ? 3'h0 : (block_mode ? (block_q | head.err) : head.err);
  assign rx_fill_level_o     = q_full ? `RXQ_LEVEL_MAX : count_q[2:0];
  assign rx_char_available_o = !q_empty;
  assign rx_queue_full_flag_o = q_full;

  // ----------------------------------------------------------------
  // Watchdog and interrupt status
  // ----------------------------------------------------------------
  logic [3:0] pre_q;
  logic [6:0] wd_cnt_q;
  logic       wd_flag_q, brk_chg_q;
  wire        bit_time = x1_mode ? tick : (tick && pre_q == `DIV_LAST);

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pre_q     <= 4'h0;
      wd_cnt_q  <= 7'h00;
      wd_flag_q <= 1'b0;
      brk_chg_q <= 1'b0;
    end
    else
    begin
      if (tick)
        pre_q <= pre_q + 4'h1;
      if (do_load || do_pop || q_empty || !wdog_en)
        wd_cnt_q <= 7'h00;
      else if (bit_time && wd_cnt_q != `WDOG_BIT_TIMES)
        wd_cnt_q <= wd_cnt_q + 7'h01;
      if (wdog_en && wd_cnt_q == `WDOG_BIT_TIMES - 7'h01 && bit_time && !do_load && !do_pop)
        wd_flag_q <= 1'b1;
      else if (cmd_clrwd)
        wd_flag_q <= 1'b0;
      if (brk_set)
        brk_chg_q <= 1'b1;
      else if (cmd_clrbrk)
        brk_chg_q <= 1'b0;
    end
  end

  assign watchdog_o     = wd_flag_q && wdog_en;
  assign break_change_o = brk_chg_q;

  // ----------------------------------------------------------------
  // Transmit address/data bit
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      tx_ad_bit_o <= 1'b0;
    else if (tx_char_start_i)
      tx_ad_bit_o <= mode1_q[`M1_AD_BIT];
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_q, rd_mux;
  wire  [7:0] chan_status = {err_view[2], err_view[1], err_view[0], overrun_q, 1'b0,
                             tx_idle_flag_i, q_full, !q_empty};
  wire  [7:0] int_status  = {5'h00, brk_chg_q, 1'b0, wd_flag_q};

  always_comb
  begin
    unique case (reg_req_i.addr)
      `REG_MODE_ZERO:   rd_mux = mode0_q;
      `REG_MODE_ONE:    rd_mux = mode1_q;
      `REG_CHAN_STATUS: rd_mux = chan_status;
      `REG_INT_STATUS:  rd_mux = int_status;
      `REG_RX_QUEUE:    rd_mux = q_empty ? 8'h00 : head.data;
      `REG_FILL_LEVEL:  rd_mux = {5'h00, rx_fill_level_o};
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rdata_q <= 8'h00;
    else
      rdata_q <= reg_req_i.rd ? rd_mux : 8'h00;
  end

  assign reg_rdata_o = rdata_q;
endmodule : uart_receiver_fifo_wakeup

// ==== hdl/uart_rx_consts.svh ====
// Register offsets, field positions, reset values and timing counts of the receive channel
`ifndef UART_RX_CONSTS_SVH
`define UART_RX_CONSTS_SVH
`define REG_MODE_ZERO      3'h0
`define REG_MODE_ONE       3'h1
`define REG_COMMAND        3'h2
`define REG_CHAN_STATUS    3'h3
`define REG_INT_STATUS     3'h4
`define REG_RX_QUEUE       3'h5
`define REG_FILL_LEVEL     3'h6
`define MODE_ZERO_RST      8'h00
`define MODE_ONE_RST       8'h00
`define M0_WDOG_EN_BIT     7
`define M0_X1_MODE_BIT     0
`define M1_AD_BIT          2
`define M1_ERR_BLOCK_BIT   5
`define M1_PAR_MODE_WAKEUP 2'h3
`define M1_PAR_MODE_FORCE  2'h1
`define M1_PAR_MODE_WITH   2'h0
`define CMD_RX_ENABLE_BIT  0
`define CMD_RX_DISABLE_BIT 1
`define CMD_RESET_ERR_BIT  2
`define CMD_CLR_BRK_BIT    3
`define CMD_CLR_WDOG_BIT   4
`define ISR_WDOG_BIT       0
`define ISR_BRK_CHANGE_BIT 2
`define RXQ_DEPTH          4'h8
`define RXQ_LEVEL_MAX      3'h7
`define SAMPLE_COUNT       4'h7
`define DIV_LAST           4'hF
`define MIN_DATA_BITS      4'h5
`define WDOG_BIT_TIMES     7'h40
`define BRK_END_EDGES      2'h2
`endif

// ==== hdl/uart_rx_pkg.sv ====
// Types shared by the receive channel
package uart_rx_pkg;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b0_0001,
    ST_START  = 5'b0_0010,
    ST_DATA   = 5'b0_0100,
    ST_FEHOLD = 5'b0_1000,
    ST_BREAK  = 5'b1_0000
  } rx_state_t;

  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
  } rx_err_t;

  typedef struct packed {
    rx_err_t    err;
    logic [7:0] data;
  } rxq_entry_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
endpackage : uart_rx_pkg

// ==== verif/testbench.sv ====
// Self-checking bench for the receive channel
`timescale 1ns/10ps
`include "uart_rx_consts.svh"

module testbench;
  import uart_rx_pkg::*;
  logic            clock_i;
  logic            sys_rst_i;
  logic            tx_idle;
  logic            tx_start;
  reg_req_t        req;
  wire logic       rxd;
  wire logic       bclk;
  wire logic       tx_ad;
  wire logic       avail;
  wire logic       full;
  wire logic       wdog;
  wire logic       brk_chg;
  wire logic [7:0] rdata;
  wire logic [2:0] fill;
  logic [7:0]      d;
  int              errors;
  int              n_compared;

  uart_line_model tx (.rxd_o(rxd), .bit_clk_o(bclk));
  uart_receiver_fifo_wakeup DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .rxd_i(rxd), .rx_bit_clock_i(bclk), .tx_idle_flag_i(tx_idle), .tx_char_start_i(tx_start),
    .tx_ad_bit_o(tx_ad), .rx_fill_level_o(fill), .rx_char_available_o(avail),
    .rx_queue_full_flag_o(full), .watchdog_o(wdog), .break_change_o(brk_chg));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock_i);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clock_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    req <= '0;
    #1 v = rdata;
  endtask : rd

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic sts(input logic [7:0] e);
    rd(`REG_CHAN_STATUS, d);
    chk(d & 8'hF7, e);
  endtask : sts

  task automatic que(input logic [7:0] e);
    rd(`REG_RX_QUEUE, d);
    chk(d, e);
  endtask : que

  task automatic adp(input logic e);
    @(posedge clock_i);
    tx_start <= 1'b1;
    @(posedge clock_i);
    tx_start <= 1'b0;
    @(posedge clock_i);
    #1 chk({7'h00, tx_ad}, {7'h00, e});
  endtask : adp

  task automatic summarize;
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Clock, timeout, sequence
  // ----------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  initial
  begin
    repeat (100000) @(posedge clock_i);
    errors++;
    summarize();
  end

  initial
  begin
    sys_rst_i = 1'b1;
    tx_idle = 1'b1;
    tx_start = 1'b0;
    req = '0;
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(`REG_MODE_ONE, d);
    chk(d, `MODE_ONE_RST);
    wr(`REG_MODE_ONE, 8'h13);
    tx.send({1'b0, 8'h55}, 8, 16, 1'b1);
    sts(8'h04);
    wr(`REG_COMMAND, 8'h01);
    tx.hold(1'b0, 4);
    tx.hold(1'b1, 48);
    sts(8'h04);
    tx.send({1'b0, 8'hA5}, 8, 16, 1'b1);
    sts(8'h05);
    que(8'hA5);
    wr(`REG_MODE_ONE, 8'h10);
    tx.send({4'h0, 5'h15}, 5, 16, 1'b1);
    que(8'h15);
    wr(`REG_MODE_ONE, 8'h13);
    wr(`REG_MODE_ZERO, 8'h01);
    tx.send({1'b0, 8'hC3}, 8, 1, 1'b1);
    que(8'hC3);
    wr(`REG_MODE_ZERO, 8'h00);
    for (int b = 0; b < 2; b++)
    begin
      wr(`REG_MODE_ONE, {2'b00, b[0], 5'b00011});
      tx.send({1'b1, 8'hA5}, 9, 16, 1'b1);
      tx.send({1'b0, 8'h5A}, 9, 16, 1'b1);
      sts(8'h25);
      que(8'hA5);
      sts({2'b00, b[0], 5'b00101});
      que(8'h5A);
      wr(`REG_COMMAND, 8'h04);
    end
    wr(`REG_MODE_ONE, 8'h13);
    for (int i = 0; i < 10; i++)
    begin
      tx.send({1'b0, 8'h10 + 8'(i)}, 8, 16, 1'b1);
      if (i == 7)
      begin
        sts(8'h07);
        chk({5'h00, fill}, 8'h07);
      end
    end
    sts(8'h17);
    for (int i = 0; i < 9; i++)
    begin
      repeat (16) @(posedge clock_i);
      que(i < 8 ? 8'h10 + 8'(i) : 8'h19);
    end
    wr(`REG_COMMAND, 8'h06);
    tx.hold(1'b0, 4);
    wr(`REG_COMMAND, 8'h01);
    tx.hold(1'b0, 188);
    sts(8'hC5);
    chk({7'h00, brk_chg}, 8'h01);
    wr(`REG_COMMAND, 8'h08);
    tx.hold(1'b1, 32);
    rd(`REG_INT_STATUS, d);
    chk(d & 8'h04, 8'h04);
    que(8'h00);
    sts(8'h04);
    wr(`REG_COMMAND, 8'h08);
    tx.send({1'b0, 8'h3C}, 8, 16, 1'b0);
    sts(8'h45);
    que(8'h3C);
    sts(8'h04);
    wr(`REG_MODE_ZERO, 8'h80);
    tx.send({1'b0, 8'h66}, 8, 16, 1'b1);
    repeat (2560) @(posedge clock_i);
    rd(`REG_INT_STATUS, d);
    chk(d & 8'h01, 8'h00);
    repeat (2048) @(posedge clock_i);
    rd(`REG_INT_STATUS, d);
    chk(d & 8'h01, 8'h01);
    chk({7'h00, wdog}, 8'h01);
    que(8'h66);
    wr(`REG_COMMAND, 8'h10);
    wr(`REG_MODE_ONE, 8'h1B);
    wr(`REG_COMMAND, 8'h02);
    tx.send({1'b0, 8'h77}, 9, 16, 1'b1);
    tx.send({1'b1, 8'h42}, 9, 16, 1'b1);
    sts(8'h25);
    que(8'h42);
    wr(`REG_COMMAND, 8'h01);
    tx.send({1'b0, 8'h99}, 9, 16, 1'b1);
    sts(8'h05);
    que(8'h99);
    @(posedge clock_i);
    tx_idle <= 1'b0;
    sts(8'h00);
    @(posedge clock_i);
    tx_idle <= 1'b1;
    wr(`REG_MODE_ONE, 8'h1F);
    adp(1'b1);
    wr(`REG_MODE_ONE, 8'h1B);
    chk({7'h00, tx_ad}, 8'h01);
    adp(1'b0);
    summarize();
  end
endmodule : testbench

// ==== verif/uart_line_model.sv ====
// Remote serial transmitter model driving the line and its bit clock
`timescale 1ns/10ps

module uart_line_model
(
  output logic rxd_o,    // Serial line, idles high
  output logic bit_clk_o // Receive clock, 16x or 1x
);
  // ----------------------------------------
  // Clock and line
  // ----------------------------------------
  initial
  begin
    rxd_o = 1'b1;
    bit_clk_o = 1'b0;
    forever #50 bit_clk_o = ~bit_clk_o;
  end

  // Line changes on the falling clock edge, centring the rising edge in the cell
  task automatic hold(input logic v, input int t);
    rxd_o = v;
    repeat (t) @(negedge bit_clk_o);
  endtask : hold

  // Start bit, bits LSB first (slot bit included in n), stop bit, idle
  task automatic send(input logic [8:0] b, input int n, input int tpb, input logic stp);
    @(negedge bit_clk_o);
    hold(1'b0, tpb);
    for (int i = 0; i < n; i++)
      hold(b[i], tpb);
    hold(stp, tpb);
    hold(1'b1, 2 * tpb);
  endtask : send
endmodule : uart_line_model

// ==== verif/uart_rx_checker.sv ====
// Concurrent checks on the receive channel ports
`timescale 1ns/10ps
`include "uart_rx_consts.svh"

module uart_rx_checker
  import uart_rx_pkg::*;
(
  input wire logic                  clock_i,              // Clock
  input wire logic                  sys_rst_i,            // Reset
  input wire uart_rx_pkg::reg_req_t reg_req_i,            // Request
  input wire logic [7:0]            reg_rdata_o,          // Read data
  input wire logic                  rxd_i,                // Line
  input wire logic                  rx_bit_clock_i,       // Bit clock
  input wire logic                  tx_idle_flag_i,       // Tx empty
  input wire logic                  tx_char_start_i,      // Tx start
  input wire logic                  tx_ad_bit_o,          // A/D bit
  input wire logic [2:0]            rx_fill_level_o,      // Level
  input wire logic                  rx_char_available_o,  // Available
  input wire logic                  rx_queue_full_flag_o, // Full
  input wire logic                  watchdog_o,           // Watchdog
  input wire logic                  break_change_o        // Break change
);
  // ----------------------------------------
  // Helper decode
  // ----------------------------------------
  wire  q_rd    = reg_req_i.rd && reg_req_i.addr == `REG_RX_QUEUE;
  wire  s_rd    = reg_req_i.rd && reg_req_i.addr == `REG_CHAN_STATUS;
  wire  brk_clr = reg_req_i.wr && reg_req_i.addr == `REG_COMMAND && reg_req_i.wdata[`CMD_CLR_BRK_BIT];
  logic ad_q;
  logic wd_en_q;

  always_ff @(posedge clock_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      ad_q    <= 1'b0;
      wd_en_q <= 1'b0;
    end
    else if (reg_req_i.wr && reg_req_i.addr == `REG_MODE_ONE)
      ad_q    <= reg_req_i.wdata[`M1_AD_BIT];
    else if (reg_req_i.wr && reg_req_i.addr == `REG_MODE_ZERO)
      wd_en_q <= reg_req_i.wdata[`M0_WDOG_EN_BIT];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  full_level_a:
    assert property (rx_queue_full_flag_o |-> rx_char_available_o && rx_fill_level_o == `RXQ_LEVEL_MAX)
    else $error("full flag without level seven");
  empty_level_a:
    assert property (!rx_char_available_o |-> rx_fill_level_o == 3'h0 && !rx_queue_full_flag_o)
    else $error("empty queue shows a level");
  status_keep_a:
    assert property (s_rd |=> rx_fill_level_o >= $past(rx_fill_level_o) &&
                     $past(rx_char_available_o) <= rx_char_available_o)
    else $error("status read removed an entry");
  status_view_a:
    assert property (s_rd |=> reg_rdata_o[2:0] == {$past(tx_idle_flag_i), $past(rx_queue_full_flag_o),
                                                    $past(rx_char_available_o)})
    else $error("status flags differ from outputs");
  pop_level_a:
    assert property (q_rd && rx_char_available_o && !rx_queue_full_flag_o |=> rx_fill_level_o <= $past(rx_fill_level_o))
    else $error("queue read left level raised");
  rdata_idle_a:
    assert property (!reg_req_i.rd |=> reg_rdata_o == 8'h00)
    else $error("read data without a read");
  avail_hold_a:
    assert property (rx_char_available_o && !q_rd |=> rx_char_available_o)
    else $error("entry lost without a queue read");
  full_hold_a:
    assert property (rx_queue_full_flag_o && !q_rd |=> rx_queue_full_flag_o)
    else $error("full queue changed without a read");
  brk_sticky_a:
    assert property (break_change_o && !brk_clr |=> break_change_o)
    else $error("break change dropped without clear");
  ad_hold_a:
    assert property (!tx_char_start_i |=> $stable(tx_ad_bit_o))
    else $error("address bit moved between characters");
  ad_load_a:
    assert property (tx_char_start_i |=> tx_ad_bit_o == $past(ad_q))
    else $error("address bit not taken from mode one");
  wdog_en_a:
    assert property (watchdog_o |-> wd_en_q)
    else $error("watchdog shown while disabled");
endmodule : uart_rx_checker

bind uart_receiver_fifo_wakeup uart_rx_checker u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .rxd_i(rxd_i), .rx_bit_clock_i(rx_bit_clock_i),
  .tx_idle_flag_i(tx_idle_flag_i), .tx_char_start_i(tx_char_start_i), .tx_ad_bit_o(tx_ad_bit_o),
  .rx_fill_level_o(rx_fill_level_o), .rx_char_available_o(rx_char_available_o),
  .rx_queue_full_flag_o(rx_queue_full_flag_o), .watchdog_o(watchdog_o), .break_change_o(break_change_o));
